// *** core/sccb_pkg.sv ***
// constants and types for the slot capability configuration bits
// assumes a 12-bit apb config-space address and a 10 mhz clock
`default_nettype none

package sccb_pkg;

   // register map
   localparam logic [11:0] GEN_CTL_ADDR     = 12'h0d4;
   localparam logic [31:0] GEN_CTL_RESET    = 32'h0000_0000;

   // field positions in the general control word
   localparam int          CFG_LSB          = 5;
   localparam int          CFG_MSB          = 12;
   localparam int          GATE_BIT         = 15;
   localparam int          PIP_BIT          = 12;
   localparam int          AIP_BIT          = 11;
   localparam int          LSP_BIT          = 10;
   localparam int          PCP_BIT          = 9;
   localparam int          ABP_BIT          = 8;
   localparam int          SLOT_BIT         = 7;
   localparam int          PFIP_BIT         = 6;
   localparam int          EMIL_BIT         = 5;

   // strap settling: two synchroniser stages plus one
   localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

   // synchroniser width: strap and power fault
   localparam int          SYNC_W           = 2;
   localparam int          SYNC_STRAP       = 0;
   localparam int          SYNC_FAULT       = 1;

   // slot hardware description, ordered as bits 12 down to 5
   typedef struct packed {
      logic power_indicator_present_cfg;
      logic attention_indicator_present_cfg;
      logic latch_sensor_present_cfg;
      logic power_controller_present_cfg;
      logic attention_button_present_cfg;
      logic slot_implemented_cfg;
      logic power_fault_input_present_cfg;
      logic interlock_present_cfg;
   } sccb_cfg_t;

   localparam sccb_cfg_t   CFG_RESET        = 8'h00;

endpackage : sccb_pkg

`default_nettype wire

// *** core/sccb_sync2.sv ***
// two-flop synchroniser for pin inputs
// assumes inputs are slow static or quasi-static levels
`timescale 1ns/1ps
`default_nettype none

module sccb_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // meta is read only by the second stage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
      end else begin
         meta <= async_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_o <= '0;
      end else begin
         sync_o <= meta;
      end
   end

endmodule : sccb_sync2

`default_nettype wire

// *** core/sccb_top.sv ***
// slot capability configuration bits of the downstream general control word
// assumes an apb4 master, an external serial-memory loader on the same clock
// and RST_I being the fundamental link reset
`timescale 1ns/1ps
`default_nettype none

module sccb_top (
   input  wire logic              CLK_I,
   input  wire logic              RST_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [11:0]       PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   input  wire logic [3:0]        PSTRB_I,
   output var  logic [31:0]       PRDATA_O,
   output var  logic              PREADY_O,
   output var  logic              PSLVERR_O,
   input  wire logic              PORT_STRAP_INPUT_I,
   input  wire logic              POWER_FAULT_INPUT_I,
   input  wire logic              EE_LOAD_VALID_I,
   input  wire logic [31:0]       EE_LOAD_DATA_I,
   output var  sccb_pkg::sccb_cfg_t SLOT_CFG_O,
   output var  logic              CLOCK_FAULT_GATE_CTL_O,
   output var  logic              REF_CLOCK_OUTPUT_EN_O
);

   logic [sccb_pkg::SYNC_W-1:0] pin_sync;
   logic                        strap_sync;
   logic                        fault_sync;
   logic                        addr_hit;
   logic                        setup_ph;
   logic                        wr_commit;
   logic [31:0]                 next_word;
   logic [31:0]                 cur_word;
   logic [1:0]                  settle_cnt;
   logic                        strap_pending;
   logic                        overridden;
   logic                        strap_take;

   // merge write data into a word, one byte lane per strobe bit
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_lanes

   // place the implemented bits in a register image, all else zero
   function automatic logic [31:0] pack_word(input sccb_pkg::sccb_cfg_t cfg,
                                             input logic                gate);
      logic [31:0] res;
      res = sccb_pkg::GEN_CTL_RESET;
      res[sccb_pkg::CFG_MSB:sccb_pkg::CFG_LSB] = cfg;
      res[sccb_pkg::GATE_BIT] = gate;
      return res;
   endfunction : pack_word

   sccb_sync2 #(
      .WIDTH (sccb_pkg::SYNC_W)
   ) u_sync (
      .clk_i   (CLK_I),
      .rst_i   (RST_I),
      .async_i ({POWER_FAULT_INPUT_I, PORT_STRAP_INPUT_I}),
      .sync_o  (pin_sync)
   );

   assign strap_sync = pin_sync[sccb_pkg::SYNC_STRAP];
   assign fault_sync = pin_sync[sccb_pkg::SYNC_FAULT];

   // apb decode; low address bits ignored, word aligned
   assign addr_hit  = (PADDR_I[11:2] == sccb_pkg::GEN_CTL_ADDR[11:2]);
   assign setup_ph  = PSEL_I & ~PENABLE_I;
   assign wr_commit = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & addr_hit & ~PSLVERR_O;
   assign cur_word  = pack_word(SLOT_CFG_O, CLOCK_FAULT_GATE_CTL_O);
   assign next_word = merge_lanes(cur_word, PWDATA_I, PSTRB_I);

   // zero wait state: ready rises in the access phase only
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
      end else begin
         PREADY_O <= setup_ph;
      end
   end

   // read image latched at setup, live value at that moment
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (setup_ph && !PWRITE_I && addr_hit) begin
         PRDATA_O <= cur_word;
      end else begin
         PRDATA_O <= 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PSLVERR_O <= 1'b0;
      end else begin
         PSLVERR_O <= setup_ph & ~addr_hit;
      end
   end

   // strap settles through the synchroniser before it is taken
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         settle_cnt    <= 2'h0;
         strap_pending <= 1'b1;
      end else if (strap_pending) begin
         if (settle_cnt == sccb_pkg::STRAP_SETTLE) begin
            strap_pending <= 1'b0;
         end else begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   assign strap_take = strap_pending & (settle_cnt == sccb_pkg::STRAP_SETTLE);

   // once memory or software has set the word, the strap no longer applies
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         overridden <= 1'b0;
      end else if (EE_LOAD_VALID_I || wr_commit) begin
         overridden <= 1'b1;
      end
   end

   // memory load wins over a same-cycle software write
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         SLOT_CFG_O <= sccb_pkg::CFG_RESET;
      end else if (EE_LOAD_VALID_I) begin
         SLOT_CFG_O <= EE_LOAD_DATA_I[sccb_pkg::CFG_MSB:sccb_pkg::CFG_LSB];
      end else if (wr_commit) begin
         SLOT_CFG_O <= next_word[sccb_pkg::CFG_MSB:sccb_pkg::CFG_LSB];
      end else if (strap_take && !overridden) begin
         SLOT_CFG_O.slot_implemented_cfg <= strap_sync;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CLOCK_FAULT_GATE_CTL_O <= 1'b0;
      end else if (EE_LOAD_VALID_I) begin
         CLOCK_FAULT_GATE_CTL_O <= EE_LOAD_DATA_I[sccb_pkg::GATE_BIT];
      end else if (wr_commit) begin
         CLOCK_FAULT_GATE_CTL_O <= next_word[sccb_pkg::GATE_BIT];
      end
   end

   // fault gates the clock only when both the pin and the gating are enabled
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         REF_CLOCK_OUTPUT_EN_O <= 1'b1;
      end else begin
         REF_CLOCK_OUTPUT_EN_O <= ~(CLOCK_FAULT_GATE_CTL_O
                                    & SLOT_CFG_O.power_fault_input_present_cfg
                                    & fault_sync);
      end
   end

   // checks
   logic wr_hi;
   logic wr_lo;
   assign wr_hi = wr_commit & PSTRB_I[1] & ~EE_LOAD_VALID_I;
   assign wr_lo = wr_commit & PSTRB_I[0] & ~EE_LOAD_VALID_I;

   sequence apb_setup_s;
      PSEL_I && !PENABLE_I;
   endsequence

   sequence apb_access_s;
      PSEL_I && PENABLE_I && PREADY_O;
   endsequence

   ready_one_cycle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      apb_setup_s |=> PREADY_O ##1 !PREADY_O)
      else $error("ready not a single access cycle");

   pip_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> SLOT_CFG_O.power_indicator_present_cfg == $past(PWDATA_I[12]))
      else $error("power indicator flag not written");

   aip_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> SLOT_CFG_O.attention_indicator_present_cfg == $past(PWDATA_I[11]))
      else $error("attention indicator flag not written");

   lsp_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> SLOT_CFG_O.latch_sensor_present_cfg == $past(PWDATA_I[10]))
      else $error("latch sensor flag not written");

   pcp_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> SLOT_CFG_O.power_controller_present_cfg == $past(PWDATA_I[9]))
      else $error("power controller flag not written");

   abp_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> SLOT_CFG_O.attention_button_present_cfg == $past(PWDATA_I[8]))
      else $error("attention button flag not written");

   slot_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_lo |=> SLOT_CFG_O.slot_implemented_cfg == $past(PWDATA_I[7]))
      else $error("slot implemented flag not written");

   pfip_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_lo |=> SLOT_CFG_O.power_fault_input_present_cfg == $past(PWDATA_I[6]))
      else $error("power fault input flag not written");

   emil_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_lo |=> SLOT_CFG_O.interlock_present_cfg == $past(PWDATA_I[5]))
      else $error("interlock flag not written");

   strap_take_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (strap_take && !overridden && !EE_LOAD_VALID_I && !wr_commit)
      |=> SLOT_CFG_O.slot_implemented_cfg == $past(strap_sync))
      else $error("strap level not taken");

   mem_load_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      EE_LOAD_VALID_I |=> SLOT_CFG_O == $past(EE_LOAD_DATA_I[12:5])
                          && CLOCK_FAULT_GATE_CTL_O == $past(EE_LOAD_DATA_I[15]))
      else $error("memory load not applied");

   clk_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      ##1 REF_CLOCK_OUTPUT_EN_O == !($past(CLOCK_FAULT_GATE_CTL_O)
          && $past(SLOT_CFG_O.power_fault_input_present_cfg) && $past(fault_sync)))
      else $error("clock enable does not follow fault gating");

   read_back_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (apb_setup_s and (!PWRITE_I && addr_hit)) ##1 apb_access_s
      |-> PRDATA_O[12:5] == SLOT_CFG_O && PRDATA_O[15] == CLOCK_FAULT_GATE_CTL_O
          && PRDATA_O[4:0] == 5'h00)
      else $error("read value differs from flags");

   unmapped_err_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (apb_setup_s and !addr_hit) |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
      else $error("unmapped access not refused");

   // lane 1 with its strobe low keeps its bits
   strb_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (wr_commit && !PSTRB_I[1] && !EE_LOAD_VALID_I)
      |=> $stable(cur_word[sccb_pkg::GATE_BIT])
          && $stable(cur_word[sccb_pkg::PIP_BIT:sccb_pkg::ABP_BIT]))
      else $error("unstrobed lane changed");

   gate_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      wr_hi |=> CLOCK_FAULT_GATE_CTL_O == $past(PWDATA_I[sccb_pkg::GATE_BIT]))
      else $error("clock fault gating flag not written");

   unmapped_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (PSEL_I && PENABLE_I && PREADY_O && PSLVERR_O && !EE_LOAD_VALID_I && !strap_take)
      |=> $stable(cur_word))
      else $error("unmapped write changed the register");

   mapped_ok_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (apb_setup_s and addr_hit) |=> !PSLVERR_O)
      else $error("mapped access refused");

   ready_idle_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      !(PSEL_I && !PENABLE_I) |=> !PREADY_O)
      else $error("ready without a setup cycle");

   err_with_ready_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      PSLVERR_O |-> PREADY_O)
      else $error("error outside the access cycle");

   // gating off or pin unused: a fault never stops the clock
   gate_off_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      !CLOCK_FAULT_GATE_CTL_O |=> REF_CLOCK_OUTPUT_EN_O)
      else $error("clock disabled with fault gating off");

   pin_off_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      !SLOT_CFG_O.power_fault_input_present_cfg |=> REF_CLOCK_OUTPUT_EN_O)
      else $error("clock disabled with fault input unused");

   // flags move only on a load, a write or the single strap sample
   cfg_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (!strap_take && !EE_LOAD_VALID_I && !wr_commit)
      |=> $stable(SLOT_CFG_O) && $stable(CLOCK_FAULT_GATE_CTL_O))
      else $error("flags changed with no load or write");

endmodule : sccb_top

`default_nettype wire

// *** verif/sccb_top_tb.sv ***
// bench for the slot capability configuration bits, apb driven
// assumes sccb_top with zero-wait apb and embedded assertions
`timescale 1ns/1ps
`default_nettype none

module sccb_top_tb;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                psel = 1'b0;
   logic                pen = 1'b0;
   logic                pwr = 1'b0;
   logic [11:0]         padr = 12'h000;
   logic [31:0]         pwd = 32'h0;
   logic [3:0]          pstb = 4'h0;
   logic [31:0]         prd;
   logic                prdy;
   logic                perr;
   logic                strap = 1'b1;
   logic                fault = 1'b0;
   logic                ld_v = 1'b0;
   logic [31:0]         ld_d = 32'h0;
   sccb_pkg::sccb_cfg_t cfg;
   logic                gate;
   logic                ref_en;
   logic [31:0]         rdata;
   logic                rerr;
   int                  miscompares = 0;
   int                  comparisons = 0;
   int                  cycles = 0;
   // writable bits: 15 and 12 down to 5
   localparam logic [31:0] WMASK = 32'h0000_9fe0;

   always #50 clk = ~clk;

   sccb_top dut_u (
      .CLK_I                  (clk),
      .RST_I                  (rst),
      .PSEL_I                 (psel),
      .PENABLE_I              (pen),
      .PWRITE_I               (pwr),
      .PADDR_I                (padr),
      .PWDATA_I               (pwd),
      .PSTRB_I                (pstb),
      .PRDATA_O               (prd),
      .PREADY_O               (prdy),
      .PSLVERR_O              (perr),
      .PORT_STRAP_INPUT_I     (strap),
      .POWER_FAULT_INPUT_I    (fault),
      .EE_LOAD_VALID_I        (ld_v),
      .EE_LOAD_DATA_I         (ld_d),
      .SLOT_CFG_O             (cfg),
      .CLOCK_FAULT_GATE_CTL_O (gate),
      .REF_CLOCK_OUTPUT_EN_O  (ref_en)
   );

   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one apb transfer; request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      padr <= a;
      pwd  <= d;
      pstb <= w ? s : 4'h0;
      @(posedge clk);
      pen <= 1'b1;
      // if pready never rises, only the bench timeout ends this wait
      @(posedge clk);
      while (prdy !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prd;
      rerr  = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   task automatic cfg_is(input logic [31:0] w);
      @(negedge clk);
      check("slot_cfg", {24'h0, cfg}, {24'h0, w[sccb_pkg::CFG_MSB:sccb_pkg::CFG_LSB]});
      check("gate", {31'h0, gate}, {31'h0, w[sccb_pkg::GATE_BIT]});
   endtask : cfg_is

   task automatic do_reset(input logic s);
      @(posedge clk);
      rst   <= 1'b1;
      strap <= s;
      cfg_is(32'h0);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // strap is applied at the fourth edge after release
      repeat (6) @(posedge clk);
      cfg_is({24'h0, s, 7'h0});
      apb(1'b0, sccb_pkg::GEN_CTL_ADDR, 32'h0, 4'h0);
      check("strap read", rdata, {24'h0, s, 7'h0});
   endtask : do_reset

   task automatic walk_bits();
      logic [31:0] w;
      for (int i = 0; i < 32; i++) begin
         w = 32'h1 << i;
         apb(1'b1, sccb_pkg::GEN_CTL_ADDR, w, 4'hf);
         cfg_is(w & WMASK);
         apb(1'b0, sccb_pkg::GEN_CTL_ADDR, 32'h0, 4'h0);
         check("walk read", rdata, w & WMASK);
      end
   endtask : walk_bits

   task automatic strobe_and_unmapped();
      apb(1'b1, sccb_pkg::GEN_CTL_ADDR, 32'hffff_ffff, 4'hf);
      // only lane 0 enabled: bits 7..5 clear, upper bits kept
      apb(1'b1, sccb_pkg::GEN_CTL_ADDR, 32'h0, 4'h1);
      cfg_is(32'h0000_9f00);
      apb(1'b1, 12'h0d8, 32'h0, 4'hf);
      check("unmapped write err", {31'h0, rerr}, 32'h1);
      apb(1'b0, 12'h0d8, 32'h0, 4'h0);
      check("unmapped read", rdata, 32'h0);
      apb(1'b0, sccb_pkg::GEN_CTL_ADDR, 32'h0, 4'h0);
      check("kept read", rdata, 32'h0000_9f00);
      check("mapped err", {31'h0, rerr}, 32'h0);
   endtask : strobe_and_unmapped

   task automatic load_and_fault();
      @(posedge clk);
      ld_v <= 1'b1;
      ld_d <= 32'h0000_8140;
      @(posedge clk);
      ld_v <= 1'b0;
      cfg_is(32'h0000_8140);
      @(posedge clk);
      fault <= 1'b1;
      // two sync stages plus one output register, with margin
      repeat (6) @(posedge clk);
      @(negedge clk);
      check("ref en gated", {31'h0, ref_en}, 32'h0);
      apb(1'b1, sccb_pkg::GEN_CTL_ADDR, 32'h0000_0040, 4'hf);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ref en no gate", {31'h0, ref_en}, 32'h1);
      apb(1'b1, sccb_pkg::GEN_CTL_ADDR, 32'h0000_8000, 4'hf);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ref en no input", {31'h0, ref_en}, 32'h1);
      @(posedge clk);
      fault <= 1'b0;
   endtask : load_and_fault

   initial begin
      do_reset(1'b1);
      walk_bits();
      strobe_and_unmapped();
      load_and_fault();
      apb(1'b1, sccb_pkg::GEN_CTL_ADDR, WMASK, 4'hf);
      // second reset in mid-run, strap now low
      do_reset(1'b0);
      end_of_test();
   end
endmodule : sccb_top_tb

`default_nettype wire
